/* File: dv/jtfm_link_sink.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Link-layer sink that paces frame acceptance
// ---------------------------------------------------------------
module jtfm_link_sink (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] pace,
  output logic            frame_ready
);
  logic [1:0] tick;

  // Pace 0 takes every frame, 1 takes one cycle in three, 2 holds off.
  // The slow pace makes frames stand for several cycles before they go.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick        <= 2'h0;
      frame_ready <= 1'b0;
    end else begin
      tick        <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
      frame_ready <= (pace == 2'h0) || (pace == 2'h1 && tick == 2'h0);
    end
  end
endmodule

/* File: dv/jtfm_mapper_tb_top.sv */
`timescale 1ns/1ps
module jtfm_mapper_tb_top;
  import jtfm_pkg::*;
  // ---------------------------------------------------------------
  // Signals and expectation table
  // ---------------------------------------------------------------
  localparam int XW = OUT_W + 9;
  typedef struct packed {
    logic [3:0] f;
    logic [1:0] m;
    logic [3:0] l;
    logic [2:0] o;
  } jtfm_row_type;
  logic             ref_clk;
  logic             rst_b;
  logic [3:0]       fmt;
  logic [1:0]       mode;
  logic             s_valid;
  logic [IN_W-1:0]  s_data;
  logic             s_ready;
  logic             f_valid;
  logic             f_ready;
  logic [OUT_W-1:0] f_data;
  logic [3:0]       f_lanes;
  logic [2:0]       f_oct;
  logic [1:0]       pace;
  logic [XW-1:0]    exp_q[$];
  logic [XW-1:0]    held;
  logic             held_v;
  int               n_errors;
  int               checks_done;
  int               cycles;
  int               n;
  const jtfm_row_type rows[22] = '{
    '{4'h4, 2'h2, 4'h3, 3'h2}, '{4'h4, 2'h1, 4'h2, 3'h2}, '{4'h4, 2'h0, 4'h1, 3'h2},
    '{4'h5, 2'h2, 4'h2, 3'h2}, '{4'h5, 2'h1, 4'h1, 3'h2}, '{4'h5, 2'h0, 4'h1, 3'h2},
    '{4'h6, 2'h2, 4'h6, 3'h2}, '{4'h6, 2'h1, 4'h3, 3'h2}, '{4'h6, 2'h0, 4'h2, 3'h2},
    '{4'h7, 2'h2, 4'h4, 3'h1}, '{4'h7, 2'h1, 4'h2, 3'h1}, '{4'h7, 2'h0, 4'h1, 3'h1},
    '{4'h8, 2'h2, 4'h4, 3'h3}, '{4'h8, 2'h1, 4'h2, 3'h3}, '{4'h8, 2'h0, 4'h1, 3'h3},
    '{4'h9, 2'h2, 4'h8, 3'h1}, '{4'h9, 2'h1, 4'h4, 3'h1}, '{4'h9, 2'h0, 4'h2, 3'h1},
    '{4'hA, 2'h2, 4'h8, 3'h5}, '{4'hA, 2'h1, 4'h4, 3'h5}, '{4'hA, 2'h0, 4'h2, 3'h5},
    '{4'h6, 2'h3, 4'h2, 3'h2}};

  jtfm_mapper #(.DEPTH(FIFO_DEPTH)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .link_format_select(fmt), .channel_mode(mode),
    .sample_valid(s_valid), .sample_data(s_data), .sample_ready(s_ready),
    .frame_valid(f_valid), .frame_ready(f_ready), .frame_data(f_data),
    .frame_lanes(f_lanes), .frame_octets(f_oct));
  jtfm_link_sink u_sink (
    .ref_clk(ref_clk), .rst_b(rst_b), .pace(pace), .frame_ready(f_ready));

  // ---------------------------------------------------------------
  // Reference frame, comparison and run control
  // ---------------------------------------------------------------
  // Fields are laid out as one MSB-first stream cut into lanes, so
  // absent channels simply leave zeros behind the used lanes.
  function automatic logic [OUT_W-1:0] ref_frame(input logic [3:0] f, input logic [1:0] m,
                                                 input logic [IN_W-1:0] d);
    int               fw, spc, lb, nch, p, s;
    logic [23:0]      cfg;
    logic [11:0]      v;
    logic [OUT_W-1:0] r;
    r = '0;
    p = 0;
    nch = (m == CH_QUAD) ? 4 : (m == CH_DUAL) ? 2 : 1;
    case (f)
      FMT_F4:  cfg = 24'h0C_01_10;
      FMT_F5:  cfg = 24'h08_01_10;
      FMT_F6:  cfg = 24'h0C_02_10;
      FMT_F7:  cfg = 24'h08_01_08;
      FMT_F8:  cfg = 24'h0C_02_18;
      FMT_F9:  cfg = 24'h08_02_08;
      default: cfg = 24'h0A_08_28;
    endcase
    fw = cfg[23:16];
    spc = cfg[15:8];
    lb = cfg[7:0];
    for (int c = 0; c < nch; c++) begin
      for (int k = 0; k < spc; k++) begin
        s = (f == FMT_F10) ? ((k < 4) ? 2 * k : 2 * k - 7) : k;
        v = (fw == 8) ? 12'(d[(c * 8 + s) * 9 + 1 +: 8]) : 12'(d[(c * 8 + s) * 9 +: 9]);
        v = (fw == 8) ? v : v << (fw - 9);
        for (int b = 0; b < fw; b++) begin
          r[OUT_W - 1 - 40 * (p / lb) - p % lb] = v[fw - 1 - b];
          p++;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [IN_W-1:0] pat(input int i);
    return {9{32'h9E37_79B9 * 32'(i + 1)}};
  endfunction

  task automatic check(input logic [XW-1:0] e, input logic [XW-1:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Offers one set and returns on the edge that takes it.
  task automatic send(input logic [IN_W-1:0] d, input bit want, input logic [XW-1:0] e);
    int w;
    w = 0;
    @(negedge ref_clk);
    s_valid = 1'b1;
    s_data = d;
    if (want) exp_q.push_back(e);
    while (s_ready !== 1'b1 && w < 200) begin
      @(negedge ref_clk);
      w++;
    end
    @(posedge ref_clk);
  endtask

  task automatic drain;
    int w;
    w = 0;
    @(negedge ref_clk);
    s_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
    while ((exp_q.size() != 0 || f_valid === 1'b1) && w < 300) begin
      @(negedge ref_clk);
      w++;
    end
    check(XW'(exp_q.size()), '0);
  endtask

  // Clock generation.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // A hang ends the run as a failure.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      give_verdict();
    end
  end

  // Every taken frame is matched in order; a stalled frame must stand.
  always @(posedge ref_clk) begin
    if (rst_b && held_v) check(held, XW'({f_lanes, f_oct, f_data}));
    if (rst_b && f_valid === 1'b1 && f_ready === 1'b1) begin
      if (exp_q.size() == 0) check('1, XW'({f_lanes, f_oct, f_data}));
      else check(exp_q.pop_front(), XW'({f_lanes, f_oct, f_data}));
    end
    held_v = rst_b && f_valid === 1'b1 && f_ready !== 1'b1;
    held = XW'({f_lanes, f_oct, f_data});
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    fmt = FMT_F4;
    mode = CH_QUAD;
    s_valid = 1'b0;
    s_data = '0;
    pace = 2'h0;
    held_v = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(XW'({2'h2, 7'h00, OUT_W'(0)}),
          XW'({s_ready, f_valid, f_lanes, f_oct, f_data}));
    rst_b = 1'b1;
    foreach (rows[i]) begin
      @(negedge ref_clk);
      fmt = rows[i].f;
      mode = rows[i].m;
      pace = i[0] ? 2'h1 : 2'h0;
      send(pat(i), 1'b1,
           XW'({rows[i].l, rows[i].o, ref_frame(rows[i].f, rows[i].m, pat(i))}));
      drain();
    end
    foreach (rows[i]) begin
      if (i < 3) begin
        @(negedge ref_clk);
        fmt = (i == 0) ? 4'h3 : (i == 1) ? 4'hB : 4'hF;
        send(pat(40 + i), 1'b0, '0);
        drain();
      end
    end
    // back-to-back sets fill the buffer while the sink holds off
    fmt = FMT_F8;
    mode = CH_DUAL;
    pace = 2'h2;
    n = 0;
    while (n < 20) begin
      @(negedge ref_clk);
      if (s_ready !== 1'b1) break;
      s_valid = 1'b1;
      s_data = pat(60 + n);
      exp_q.push_back(XW'({4'h2, 3'h3, ref_frame(FMT_F8, CH_DUAL, pat(60 + n))}));
      n++;
    end
    // One set waits in the frame register, the buffer holds the rest.
    check(XW'(FIFO_DEPTH + 1), XW'(n));
    pace = 2'h1;
    drain();
    // mid-run reset clears a stalled frame and the buffer
    pace = 2'h2;
    @(negedge ref_clk);
    s_valid = 1'b1;
    s_data = pat(90);
    repeat (3) @(negedge ref_clk);
    s_valid = 1'b0;
    rst_b = 1'b0;
    @(negedge ref_clk);
    check(XW'({2'h2, 7'h00, OUT_W'(0)}),
          XW'({s_ready, f_valid, f_lanes, f_oct, f_data}));
    rst_b = 1'b1;
    pace = 2'h0;
    send(pat(91), 1'b1, XW'({4'h2, 3'h3, ref_frame(FMT_F8, CH_DUAL, pat(91))}));
    drain();
    give_verdict();
  end
endmodule

/* File: hdl/jtfm_fifo.sv */
`timescale 1ns/1ps
// Sample-set buffer; in_ready is registered so the source sees a clean flag.
module jtfm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = AW'(0) + (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_in_ready;
  logic             push;
  logic             pop;

  // Pointer and occupancy update.
  always_comb begin
    push          = in_valid && in_ready;
    pop           = out_valid && out_ready;
    next_wr_ptr   = push ? AW'((32'(wr_ptr) + 1) % DEPTH) : wr_ptr;
    next_rd_ptr   = pop ? AW'((32'(rd_ptr) + 1) % DEPTH) : rd_ptr;
    next_count    = count + (AW+1)'(push) - (AW+1)'(pop);
    next_in_ready = next_count != FULL_CNT;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // Storage has no reset; only the count entries from rd_ptr on are ever read.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
endmodule

/* File: hdl/jtfm_mapper.sv */
`timescale 1ns/1ps
// Functional notes
// - Format 4: 3/2/1 lanes; lane 0 ends with B0[8:5], zero if single.
// - Format 4 lane 1: B0[4:0],000 then C0[8:1] quad, 0x00 dual.
// - Format 4 lane 2: C0[0],000 then D0[8:0],000.
// - Format 5: lane 0 A0,B0 (0x00 single); lane 1 C0,D0.
// - Format 6: 12-bit fields A0..D1 packed continuously, two octets per lane.
// - Format 7: one octet per lane, lane k holds channel k sample.
// - Format 8: lane k holds two 12-bit fields of channel k.
// - Format 9: two lanes per channel, lower sample 0, upper sample 1.
// - Format 10: lane pair per channel, four 10-bit fields each.
// - Lanes of absent channels are not sent and stay zero.
// - Samples go MSB first; surplus LSBs of wider fields are zero.
// - Tail bits beyond the frame's octets are driven as zero.
module jtfm_mapper
  import jtfm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [3:0]        link_format_select,
  input  wire logic [1:0]        channel_mode,
  input  wire logic              sample_valid,
  input  wire logic [IN_W-1:0]   sample_data,
  output logic                   sample_ready,
  output logic                   frame_valid,
  input  wire logic              frame_ready,
  output logic      [OUT_W-1:0]  frame_data,
  output logic      [3:0]        frame_lanes,
  output logic      [2:0]        frame_octets
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Lanes in use for a format and channel mode; zero means unsupported.
  function automatic logic [3:0] lane_total(input logic [3:0] f,
                                            input logic [1:0] m);
    logic [3:0] q;
    q = 4'h0;
    case (f)
      FMT_F4:  q = 4'h3;
      FMT_F5:  q = 4'h2;
      FMT_F6:  q = 4'h6;
      FMT_F7:  q = 4'h4;
      FMT_F8:  q = 4'h4;
      FMT_F9:  q = 4'h8;
      FMT_F10: q = 4'h8;
      default: q = 4'h0;
    endcase
    if (m == CH_DUAL) begin
      q = (f == FMT_F5) ? 4'h1 : (f == FMT_F4) ? 4'h2 : q >> 1;
    end else if (m != CH_QUAD) begin
      q = (f == FMT_F4 || f == FMT_F5) ? 4'h1 :
          (f == FMT_F6) ? 4'h2 : q >> 2;
    end
    return q;
  endfunction

  function automatic logic [2:0] octet_total(input logic [3:0] f);
    logic [2:0] q;
    case (f)
      FMT_F4:  q = OCT_F4;
      FMT_F5:  q = OCT_F5;
      FMT_F6:  q = OCT_F6;
      FMT_F7:  q = OCT_F7;
      FMT_F8:  q = OCT_F8;
      FMT_F9:  q = OCT_F9;
      FMT_F10: q = OCT_F10;
      default: q = 3'h0;
    endcase
    return q;
  endfunction

  // Mask of the bits a frame may carry: used lanes, used octets.
  function automatic logic [OUT_W-1:0] used_mask(input logic [3:0] l,
                                                 input logic [2:0] o);
    logic [OUT_W-1:0] q;
    logic [LANE_W-1:0] lm;
    q  = '0;
    lm = ~({LANE_W{1'b1}} >> (8 * int'(o)));
    for (int k = 0; k < LANES; k++) begin
      if (k < int'(l)) begin
        q[OUT_W-1-k*LANE_W -: LANE_W] = lm;
      end
    end
    return q;
  endfunction

  // Builds one frame. Absent channels are zeroed first, which yields the
  // zero nibbles and octets that single and dual parts show.
  // In 8-bit formats the sample is the upper eight bits of the input.
  function automatic logic [OUT_W-1:0] map_frame(input logic [3:0] f,
                                                 input logic [1:0] m,
                                                 input logic [IN_W-1:0] d);
    logic [SAMPLE_W-1:0] s [CHANNELS][SETS];
    logic [LANE_W-1:0]   ln [LANES];
    logic [95:0]         st;
    logic [OUT_W-1:0]    q;
    logic [3:0]          lt;
    int                  nch;
    nch = (m == CH_QUAD) ? 4 : (m == CH_DUAL) ? 2 : 1;
    lt  = lane_total(f, m);
    st  = '0;
    q   = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      for (int n = 0; n < SETS; n++) begin
        s[c][n] = (c < nch) ? d[(c*SETS+n)*SAMPLE_W +: SAMPLE_W] : '0;
      end
    end
    for (int k = 0; k < LANES; k++) begin
      ln[k] = '0;
    end
    case (f)
      FMT_F4: begin
        ln[0] = {s[0][0], 3'h0, s[1][0][8:5], 24'h0};
        ln[1] = {s[1][0][4:0], 3'h0, s[2][0][8:1], 24'h0};
        ln[2] = {s[2][0][0], 3'h0, s[3][0], 3'h0, 24'h0};
      end
      FMT_F5: begin
        ln[0] = {s[0][0][8:1], s[1][0][8:1], 24'h0};
        ln[1] = {s[2][0][8:1], s[3][0][8:1], 24'h0};
      end
      FMT_F6: begin
        for (int c = 0; c < CHANNELS; c++) begin
          for (int n = 0; n < 2; n++) begin
            st[95-(c*2+n)*12 -: 12] = {s[c][n], 3'h0};
          end
        end
        for (int k = 0; k < 6; k++) begin
          ln[k] = {st[95-k*16 -: 16], 24'h0};
        end
      end
      FMT_F7: begin
        for (int k = 0; k < CHANNELS; k++) begin
          ln[k] = {s[k][0][8:1], 32'h0};
        end
      end
      FMT_F8: begin
        for (int k = 0; k < CHANNELS; k++) begin
          ln[k] = {s[k][0], 3'h0, s[k][1], 3'h0, 16'h0};
        end
      end
      FMT_F9: begin
        for (int k = 0; k < CHANNELS; k++) begin
          ln[2*k]   = {s[k][0][8:1], 32'h0};
          ln[2*k+1] = {s[k][1][8:1], 32'h0};
        end
      end
      FMT_F10: begin
        for (int k = 0; k < CHANNELS; k++) begin
          for (int j = 0; j < 2; j++) begin
            ln[2*k+j] = {s[k][j], 1'b0, s[k][j+2], 1'b0,
                         s[k][j+4], 1'b0, s[k][j+6], 1'b0};
          end
        end
      end
      default: begin
        ln[0] = '0;
      end
    endcase
    for (int k = 0; k < LANES; k++) begin
      if (k < int'(lt)) begin
        q[OUT_W-1-k*LANE_W -: LANE_W] = ln[k];
      end
    end
    return q;
  endfunction

  // ---------------------------------------------------------------
  // Sample-set buffer
  // ---------------------------------------------------------------
  logic            buf_valid;
  logic            buf_ready;
  logic [IN_W-1:0] buf_data;

  jtfm_fifo #(
    .WIDTH (IN_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (sample_valid),
    .in_data   (sample_data),
    .in_ready  (sample_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_ready)
  );

  // ---------------------------------------------------------------
  // Frame output register
  // ---------------------------------------------------------------
  logic             pop;
  logic [3:0]       pop_lanes;
  logic [3:0]       frame_fmt;
  logic [1:0]       frame_chan;
  logic             next_frame_valid;
  logic [OUT_W-1:0] next_frame_data;
  logic [3:0]       next_frame_lanes;
  logic [2:0]       next_frame_octets;
  logic [3:0]       next_frame_fmt;
  logic [1:0]       next_frame_chan;

  // A held frame stalls the buffer, so back-pressure reaches the source.
  // The format is sampled per frame; a change takes effect on the next set.
  // An unsupported format consumes the set and emits nothing.
  always_comb begin
    buf_ready         = !frame_valid || frame_ready;
    pop               = buf_valid && buf_ready;
    pop_lanes         = lane_total(link_format_select, channel_mode);
    next_frame_valid  = frame_valid && !frame_ready;
    next_frame_data   = frame_data;
    next_frame_lanes  = frame_lanes;
    next_frame_octets = frame_octets;
    next_frame_fmt    = frame_fmt;
    next_frame_chan   = frame_chan;
    if (pop) begin
      next_frame_valid  = pop_lanes != 4'h0;
      next_frame_data   = map_frame(link_format_select, channel_mode, buf_data);
      next_frame_lanes  = pop_lanes;
      next_frame_octets = octet_total(link_format_select);
      next_frame_fmt    = link_format_select;
      next_frame_chan   = channel_mode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_valid  <= 1'b0;
      frame_data   <= '0;
      frame_lanes  <= 4'h0;
      frame_octets <= 3'h0;
      frame_fmt    <= 4'h0;
      frame_chan   <= CH_SINGLE;
    end else begin
      frame_valid  <= next_frame_valid;
      frame_data   <= next_frame_data;
      frame_lanes  <= next_frame_lanes;
      frame_octets <= next_frame_octets;
      frame_fmt    <= next_frame_fmt;
      frame_chan   <= next_frame_chan;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  fmt4_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid && frame_fmt == FMT_F4 && frame_chan == CH_SINGLE
    |-> frame_data[OUT_W-13 -: 4] == 4'h0)
    else $error("format 4 single lane 0 nibble not zero");

  fmt4_pads_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid && frame_fmt == FMT_F4 && frame_chan == CH_QUAD
    |-> frame_data[OUT_W-LANE_W-6 -: 3] == 3'h0
        && frame_data[OUT_W-2*LANE_W-2 -: 3] == 3'h0
        && frame_data[OUT_W-2*LANE_W-14 -: 3] == 3'h0)
    else $error("format 4 pad bits not zero");

  fmt6_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid && frame_fmt == FMT_F6 && frame_chan == CH_SINGLE
    |-> frame_data[OUT_W-LANE_W-9 -: 8] == 8'h00)
    else $error("format 6 single B octet not zero");

  fmt7_msb_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pop && link_format_select == FMT_F7
    |=> frame_data[OUT_W-1 -: 8] == $past(buf_data[8:1]))
    else $error("format 7 lane 0 octet not A0 upper bits");

  fmt8_pad_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid && frame_fmt == FMT_F8
    |-> frame_data[OUT_W-10 -: 3] == 3'h0
        && frame_data[OUT_W-22 -: 3] == 3'h0)
    else $error("format 8 field pad not zero");

  fmt10_pad_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid && frame_fmt == FMT_F10
    |-> !frame_data[OUT_W-LANE_W] && !frame_data[OUT_W-LANE_W+10]
        && !frame_data[OUT_W-LANE_W+20] && !frame_data[OUT_W-LANE_W+30])
    else $error("format 10 field pad not zero");

  lane_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid |-> frame_lanes == lane_total(frame_fmt, frame_chan))
    else $error("lane count does not match format");

  tail_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid
    |-> (frame_data & ~used_mask(frame_lanes, frame_octets)) == '0)
    else $error("bits beyond the frame are not zero");

  frame_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
    else $error("stalled frame changed");
endmodule

/* File: shared/jtfm_pkg.sv */
package jtfm_pkg;
  // ---------------------------------------------------------------
  // Geometry of the sample set and of the lane frame
  // ---------------------------------------------------------------
  localparam int SAMPLE_W   = 9;
  localparam int CHANNELS   = 4;
  localparam int SETS       = 8;
  localparam int LANES      = 8;
  localparam int LANE_W     = 40;
  localparam int IN_W       = SAMPLE_W * SETS * CHANNELS;
  localparam int OUT_W      = LANE_W * LANES;
  localparam int FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // Link format codes and channel modes
  // ---------------------------------------------------------------
  localparam logic [3:0] FMT_F4  = 4'h4;
  localparam logic [3:0] FMT_F5  = 4'h5;
  localparam logic [3:0] FMT_F6  = 4'h6;
  localparam logic [3:0] FMT_F7  = 4'h7;
  localparam logic [3:0] FMT_F8  = 4'h8;
  localparam logic [3:0] FMT_F9  = 4'h9;
  localparam logic [3:0] FMT_F10 = 4'hA;
  localparam logic [1:0] CH_SINGLE = 2'h0;
  localparam logic [1:0] CH_DUAL   = 2'h1;
  localparam logic [1:0] CH_QUAD   = 2'h2;

  // ---------------------------------------------------------------
  // Octets per lane per frame
  // ---------------------------------------------------------------
  localparam logic [2:0] OCT_F4  = 3'h2;
  localparam logic [2:0] OCT_F5  = 3'h2;
  localparam logic [2:0] OCT_F6  = 3'h2;
  localparam logic [2:0] OCT_F7  = 3'h1;
  localparam logic [2:0] OCT_F8  = 3'h3;
  localparam logic [2:0] OCT_F9  = 3'h1;
  localparam logic [2:0] OCT_F10 = 3'h5;
endpackage
